// ===== design/ccs_defines.vh
`ifndef CCS_DEFINES_VH
`define CCS_DEFINES_VH
// =====================================
// major operation codes (octal 00,53,71,73,76,77)
`define CCS_OP_HALT      6'h00
`define CCS_OP_RFX       6'h2b
`define CCS_OP_IO_LO     6'h39
`define CCS_OP_CH_LO     6'h3b
`define CCS_OP_CH_HI     6'h3e
`define CCS_OP_EXT       6'h3f
// =====================================
// 77 extension codes, three octal digits in 9 bits; exempt prefixes two digits in 6 bits, channel limit one digit
`define CCS_X_LDCF       9'h19c
`define CCS_X_SETM       9'h190
`define CCS_X_CLRM       9'h191
`define CCS_X_CIR2A      9'h1a0
`define CCS_X_A2CIR      9'h1a1
`define CCS_X_A2ISR      9'h1a2
`define CCS_X_A2OSR      9'h1a3
`define CCS_X_ARM        9'h1a8
`define CCS_X_EX72       6'h3a
`define CCS_X_EX71       6'h39
`define CCS_X_CHMAX      3'h4
// =====================================
// condition flag bit positions
`define CCS_F_BJUMP      0
`define CCS_F_DLOAD      1
`define CCS_F_OREL       2
`define CCS_F_PSJMP      3
`define CCS_F_INTEN      4
`define CCS_F_PSTATE     5
`define CCS_F_ALWAYS     6'h10
// =====================================
// register file map
`define CCS_RF_CURADDR   6'h00
`define CCS_RF_LASTADDR  6'h08
`define CCS_RF_SRCH_CUR  6'h10
`define CCS_RF_MOVE_SRC  6'h11
`define CCS_RF_CLK_TIME  6'h12
`define CCS_RF_TYPE_CUR  6'h13
`define CCS_RF_TEMP      6'h14
`define CCS_RF_SRCH_END  6'h18
`define CCS_RF_MOVE_DST  6'h19
`define CCS_RF_CLK_CMP   6'h1a
`define CCS_RF_GUARD     6'h20
// =====================================
// reset values and timing
`define CCS_RST_STATE3   3'h0
`define CCS_RST_FLAGS    6'h00
`define CCS_RST_MASK     12'h000
`define CCS_RF_CYCLE_NS  500
`define CCS_CLK_NS       100
`endif

// ===== design/ccs_core.v
`timescale 1ns/1ps
`include "ccs_defines.vh"

// How it works
// [RULE1] instruction state prefixes program counter addresses
// [RULE2] operand state prefixes relocated operand addresses
// [RULE3] channel index ORed into channel designator
// [RULE4] channel index copied to/from accumulator
// [RULE5] outside executive only flag 04 visible
// [RULE6] 77.634 loads all flags; events set/clear
// [RULE7] fixed meaning for each flag bit
// [RULE8] hidden holding register with character rotation
// [RULE9] twelve mask bits, set and clear ops
// [RULE10] storage via address and word registers
// [RULE11] odd parity on low outgoing byte
// [RULE12] address bus from four sources
// [RULE13] console switch enters monitor state
// [RULE14] armed boundary jump enters program state
// [RULE15] privileged attempts in program state trap
// [RULE16] 64 word register file, op 53
// [RULE17] channel address entries in file
// [RULE18] search, move, clock, typewriter entries
// [RULE19] reserved entries as scratch only safely
// [RULE20] forced return clears program state flag
module ccs_core (
   // clock and reset
   input  wire        CLOCK,
   input  wire        RESET_N,
   // console
   input  wire        EXEC_ENTER,
   input  wire        EXEC_LEAVE,
   // instruction from sequencer
   input  wire        OP_VALID,
   input  wire [5:0]  OP_CODE,
   input  wire [8:0]  OP_EXT,
   input  wire [2:0]  OP_CH,
   input  wire        OP_IS_JUMP,
   input  wire [5:0]  OP_RF_ADDR,
   input  wire [23:0] OP_ACC,
   // flag events
   input  wire [5:0]  FLAG_SET,
   input  wire [5:0]  FLAG_CLR,
   // address sources
   input  wire        ISR_USE,
   input  wire        OPERAND_REF,
   input  wire [1:0]  ADDR_SEL,
   input  wire [14:0] PC,
   input  wire [17:0] INSTR_ADDR,
   input  wire [17:0] BLOCK_ADDR,
   input  wire [17:0] BREAK_ADDR,
   // storage and data bus
   input  wire        STO_READ,
   input  wire        STO_WRITE,
   input  wire        STO_RVALID,
   input  wire [27:0] STO_RDATA,
   input  wire        DB_LOAD,
   input  wire [23:0] DB_IN,
   input  wire [1:0]  DB_SHIFT,
   input  wire        IO_SEND,
   // block control file port
   input  wire        BC_REQ,
   input  wire        BC_WR,
   input  wire [3:0]  BC_KIND,
   input  wire [2:0]  BC_CHAN,
   input  wire [23:0] BC_WDATA,
   // state outputs
   output reg         EXEC_MODE,
   output reg         PROG_STATE,
   output reg  [5:0]  FLAGS,
   output reg  [11:0] INT_MASK,
   output reg  [2:0]  CHAN_IDX,
   output reg  [2:0]  INSTR_STATE,
   output reg  [2:0]  OPER_STATE,
   output reg         TRAP,
   // results
   output reg  [23:0] ACC_OUT,
   output reg         ACC_VALID,
   output reg  [2:0]  IO_CHAN,
   output reg         CHAN_VALID,
   output reg  [23:0] IO_DATA,
   output reg         IO_PARITY,
   output reg         IO_VALID,
   output reg  [17:0] STO_ADDR,
   output reg  [27:0] STO_WDATA,
   output reg         STO_WE,
   output reg         STO_RE,
   output reg  [23:0] RF_RDATA,
   output reg         RF_RVALID,
   output reg         BC_ACK
);

   // ======================================
   // state
   reg  [5:0]  flags_reg;
   reg  [5:0]  flags_next;
   reg         exec_reg;
   reg         exec_next;
   reg  [11:0] mask_reg;
   reg  [11:0] mask_next;
   reg  [2:0]  cir_reg;
   reg  [2:0]  cir_next;
   reg  [2:0]  isr_reg;
   reg  [2:0]  isr_next;
   reg  [2:0]  osr_reg;
   reg  [2:0]  osr_next;
   reg  [23:0] dbr_reg;
   reg  [23:0] rf_mem [0:63];
   reg  [17:0] addr_mux;
   reg  [5:0]  bc_addr;

   // ======================================
   // decode
   wire is_ext   = (OP_CODE == `CCS_OP_EXT);
   wire is_x     = OP_VALID & is_ext;
   wire is_rfx   = (OP_CODE == `CCS_OP_RFX);
   wire in_prog  = exec_reg & flags_reg[`CCS_F_PSTATE];
   wire exempt   = is_ext & ((OP_EXT[8:3] == `CCS_X_EX72) | (OP_EXT[8:3] == `CCS_X_EX71));
   wire halt_op  = (OP_CODE == `CCS_OP_HALT) & (OP_EXT[8:6] == 3'h0);
   wire priv_op  = (OP_CODE >= `CCS_OP_IO_LO) & ~exempt;
   wire rf_low   = is_rfx & (OP_RF_ADDR < `CCS_RF_GUARD);
   // [RULE15] program state trap
   wire trap_now = OP_VALID & in_prog & (halt_op | priv_op | rf_low);
   // monitor and non-exec modes run everything present
   wire op_do    = OP_VALID & ~trap_now;
   wire x_do     = is_x & ~trap_now;
   // [RULE3] channel-indexed ops
   wire ch_op    = op_do & (((OP_CODE >= `CCS_OP_CH_LO) & (OP_CODE <= `CCS_OP_CH_HI)) |
                            (is_ext & (OP_EXT[8:6] <= `CCS_X_CHMAX)));
   wire rf_op    = op_do & is_rfx;

   // ======================================
   // character rotation into the holding register
   function [23:0] ccs_rot;
      input [23:0] d;
      input [1:0]  n;
      begin
         case (n)
            2'h1:    ccs_rot = {d[17:0], d[23:18]};
            2'h2:    ccs_rot = {d[11:0], d[23:12]};
            2'h3:    ccs_rot = {d[5:0],  d[23:6]};
            default: ccs_rot = d;
         endcase
      end
   endfunction

   // ======================================
   // register file entry for a block control request
   always @* begin
      // [RULE17] per-channel address words
      // [RULE18] fixed service entries
      case (BC_KIND)
         4'h0:    bc_addr = `CCS_RF_CURADDR  | {3'h0, BC_CHAN};
         4'h1:    bc_addr = `CCS_RF_LASTADDR | {3'h0, BC_CHAN};
         4'h2:    bc_addr = `CCS_RF_SRCH_CUR;
         4'h3:    bc_addr = `CCS_RF_SRCH_END;
         4'h4:    bc_addr = `CCS_RF_MOVE_SRC;
         4'h5:    bc_addr = `CCS_RF_MOVE_DST;
         4'h6:    bc_addr = `CCS_RF_CLK_TIME;
         4'h7:    bc_addr = `CCS_RF_CLK_CMP;
         4'h8:    bc_addr = `CCS_RF_TYPE_CUR;
         default: bc_addr = `CCS_RF_TEMP | {4'h0, BC_CHAN[1:0]};
      endcase
   end

   // ======================================
   // storage address bus source select
   always @* begin
      // [RULE12] four address sources
      case (ADDR_SEL)
         2'h0: begin
            // [RULE1] prefix program counter
            addr_mux = {(exec_reg & ISR_USE) ? isr_reg : 3'h0, PC};
         end
         2'h1: begin
            // [RULE2] operand relocation
            if (exec_reg & flags_reg[`CCS_F_OREL] & OPERAND_REF) begin
               addr_mux = {osr_reg, INSTR_ADDR[14:0]};
            end else begin
               addr_mux = INSTR_ADDR;
            end
         end
         2'h2:    addr_mux = BLOCK_ADDR;
         default: addr_mux = BREAK_ADDR;
      endcase
   end

   // ======================================
   // mode, flag and small register next values
   always @* begin
      flags_next = flags_reg;
      exec_next  = exec_reg;
      mask_next  = mask_reg;
      cir_next   = cir_reg;
      isr_next   = isr_reg;
      osr_next   = osr_reg;
      // [RULE13] console enters monitor
      if (EXEC_ENTER) begin
         exec_next = 1'b1;
         flags_next[`CCS_F_PSTATE] = 1'b0;
      end else if (EXEC_LEAVE) begin
         exec_next = 1'b0;
         flags_next[`CCS_F_PSTATE] = 1'b0;
      end
      // [RULE6] whole flag load
      if (x_do & (OP_EXT == `CCS_X_LDCF)) begin
         flags_next = OP_ACC[5:0];
      end
      // [RULE14] arm then jump
      if (x_do & (OP_EXT == `CCS_X_ARM)) begin
         flags_next[`CCS_F_BJUMP] = 1'b1;
      end
      if (op_do & OP_IS_JUMP & exec_reg & flags_reg[`CCS_F_BJUMP]) begin
         flags_next[`CCS_F_BJUMP]  = 1'b0;
         flags_next[`CCS_F_PSJMP]  = 1'b1;
         flags_next[`CCS_F_PSTATE] = 1'b1;
      end
      // [RULE6] event set wins over clear
      flags_next = (flags_next & ~FLAG_CLR) | FLAG_SET;
      // [RULE20] forced return clears state
      if (trap_now) begin
         flags_next[`CCS_F_PSTATE] = 1'b0;
      end
      // [RULE9] mask set and clear
      if (x_do & (OP_EXT == `CCS_X_SETM)) begin
         mask_next = mask_reg | OP_ACC[11:0];
      end
      if (x_do & (OP_EXT == `CCS_X_CLRM)) begin
         mask_next = mask_reg & ~OP_ACC[11:0];
      end
      // [RULE4] load channel index, instruction state and operand state
      if (x_do & (OP_EXT == `CCS_X_A2CIR)) begin
         cir_next = OP_ACC[2:0];
      end
      if (x_do & (OP_EXT == `CCS_X_A2ISR)) begin
         isr_next = OP_ACC[2:0];
      end
      if (x_do & (OP_EXT == `CCS_X_A2OSR)) begin
         osr_next = OP_ACC[2:0];
      end
   end

   // ======================================
   // registers and outputs
   always @(posedge CLOCK or negedge RESET_N) begin
      if (!RESET_N) begin
         flags_reg   <= `CCS_RST_FLAGS;
         exec_reg    <= 1'b0;
         mask_reg    <= `CCS_RST_MASK;
         cir_reg     <= `CCS_RST_STATE3;
         isr_reg     <= `CCS_RST_STATE3;
         osr_reg     <= `CCS_RST_STATE3;
         dbr_reg     <= 24'h000000;
         EXEC_MODE   <= 1'b0;
         PROG_STATE  <= 1'b0;
         FLAGS       <= `CCS_RST_FLAGS;
         INT_MASK    <= `CCS_RST_MASK;
         CHAN_IDX    <= `CCS_RST_STATE3;
         INSTR_STATE <= `CCS_RST_STATE3;
         OPER_STATE  <= `CCS_RST_STATE3;
         TRAP        <= 1'b0;
         ACC_OUT     <= 24'h000000;
         ACC_VALID   <= 1'b0;
         IO_CHAN     <= 3'h0;
         CHAN_VALID  <= 1'b0;
         IO_DATA     <= 24'h000000;
         IO_PARITY   <= 1'b0;
         IO_VALID    <= 1'b0;
         STO_ADDR    <= 18'h00000;
         STO_WDATA   <= 28'h0000000;
         STO_WE      <= 1'b0;
         STO_RE      <= 1'b0;
         BC_ACK      <= 1'b0;
      end else begin
         flags_reg   <= flags_next;
         exec_reg    <= exec_next;
         mask_reg    <= mask_next;
         cir_reg     <= cir_next;
         isr_reg     <= isr_next;
         osr_reg     <= osr_next;
         EXEC_MODE   <= exec_next;
         PROG_STATE  <= exec_next & flags_next[`CCS_F_PSTATE];
         // [RULE5] only interrupt enable outside exec
         // [RULE7] bit layout kept as stored
         FLAGS       <= exec_next ? flags_next : (flags_next & `CCS_F_ALWAYS);
         INT_MASK    <= mask_next;
         CHAN_IDX    <= cir_next;
         INSTR_STATE <= isr_next;
         OPER_STATE  <= osr_next;
         TRAP        <= trap_now;
         // [RULE4] copy index to accumulator
         ACC_VALID   <= x_do & (OP_EXT == `CCS_X_CIR2A);
         if (x_do & (OP_EXT == `CCS_X_CIR2A)) begin
            ACC_OUT <= {OP_ACC[23:3], cir_reg};
         end
         // [RULE3] OR index into designator
         CHAN_VALID  <= ch_op;
         if (ch_op) begin
            IO_CHAN <= OP_CH | cir_reg;
         end
         // [RULE8] holding register with rotation; read data wins over bus load
         if (STO_RVALID) begin
            dbr_reg <= ccs_rot(STO_RDATA[23:0], DB_SHIFT);
         end else if (DB_LOAD) begin
            dbr_reg <= ccs_rot(DB_IN, DB_SHIFT);
         end
         // [RULE11] odd parity low byte only
         IO_VALID    <= IO_SEND;
         if (IO_SEND) begin
            IO_DATA   <= dbr_reg;
            IO_PARITY <= ~^dbr_reg[11:0];
         end
         // [RULE10] address and word registers
         STO_WE      <= STO_WRITE;
         STO_RE      <= STO_READ & ~STO_WRITE;
         if (STO_WRITE | STO_READ) begin
            STO_ADDR <= addr_mux;
         end
         if (STO_WRITE) begin
            STO_WDATA <= {~^dbr_reg[23:18], ~^dbr_reg[17:12],
                          ~^dbr_reg[11:6], ~^dbr_reg[5:0], dbr_reg};
         end else if (STO_RVALID) begin
            STO_WDATA <= STO_RDATA;
         end
         // op 53 owns the file port; block control gets no ack and must retry
         BC_ACK      <= BC_REQ & ~rf_op;
      end
   end

   // ======================================
   // register file: single cycle here, faster than its nominal cycle
   always @(posedge CLOCK or negedge RESET_N) begin
      if (!RESET_N) begin
         RF_RDATA  <= 24'h000000;
         RF_RVALID <= 1'b0;
      end else begin
         RF_RVALID <= rf_op & ~OP_EXT[8];
         // [RULE16] transfer reaches every entry outside program state; there entries below 040 trap
         if (rf_op) begin
            if (!OP_EXT[8]) begin
               RF_RDATA <= rf_mem[OP_RF_ADDR];
            end
         end else if (BC_REQ) begin
            if (!BC_WR) begin
               RF_RDATA <= rf_mem[bc_addr];
            end
         end
      end
   end

   // ======================================
   // file writes kept out of the reset process: contents survive reset
   always @(posedge CLOCK) begin
      // [RULE16] write side of op 53
      if (rf_op & OP_EXT[8]) begin
         rf_mem[OP_RF_ADDR] <= OP_ACC;
      end else if (~rf_op & BC_REQ & BC_WR) begin
         rf_mem[bc_addr] <= BC_WDATA;
      end
   end

endmodule // ccs_core

// ===== testbench/ccs_properties.sv
`timescale 1ns/1ps
// ======
// port checker for the control core
module ccs_properties (
   // clock, reset and inputs
   input logic        CLOCK, RESET_N, EXEC_ENTER, EXEC_LEAVE, OP_VALID, OP_IS_JUMP,
   input logic        BC_REQ, IO_SEND,
   input logic [5:0]  OP_CODE, FLAG_SET, FLAG_CLR,
   input logic [8:0]  OP_EXT,
   input logic [2:0]  OP_CH,
   input logic [23:0] OP_ACC,
   // outputs
   input logic        EXEC_MODE, PROG_STATE, TRAP, CHAN_VALID, IO_PARITY, IO_VALID, BC_ACK,
   input logic [5:0]  FLAGS,
   input logic [11:0] INT_MASK,
   input logic [2:0]  CHAN_IDX, IO_CHAN,
   input logic [23:0] IO_DATA
);
   default clocking @(posedge CLOCK); endclocking
   default disable iff (!RESET_N);
   // an instruction's flag writes override console strobes, so such cycles are left out
   wire calm = !EXEC_ENTER && !EXEC_LEAVE;
   wire prog = EXEC_MODE && PROG_STATE;
   sequence s_ext(x);
      calm && OP_VALID && !prog && OP_CODE == 6'h3f && OP_EXT == x;
   endsequence
   sequence s_armed;
      calm && EXEC_MODE && !PROG_STATE && FLAGS[0] && FLAG_CLR == 6'h00;
   endsequence
   sequence s_jump;
      OP_VALID && OP_IS_JUMP;
   endsequence
   property p_halt;
      calm && OP_VALID && prog && OP_CODE == 6'h00 && OP_EXT[8:6] == 3'h0
         |=> TRAP && !PROG_STATE && !FLAGS[5];
   endproperty
   a_halt: assert property (p_halt) else $error("halt not trapped");
   property p_exempt;
      calm && OP_VALID && prog && OP_CODE == 6'h3f && OP_EXT[8:3] inside {6'h39, 6'h3a}
         |=> !TRAP && PROG_STATE;
   endproperty
   a_exempt: assert property (p_exempt) else $error("exempt op trapped");
   property p_chan;
      calm && OP_VALID && !prog && OP_CODE inside {[6'h3b:6'h3e]}
         |=> CHAN_VALID && IO_CHAN == ($past(OP_CH) | $past(CHAN_IDX));
   endproperty
   a_chan: assert property (p_chan) else $error("channel not merged");
   property p_hide;
      !EXEC_MODE |-> (FLAGS & 6'h2f) == 6'h00;
   endproperty
   a_hide: assert property (p_hide) else $error("flags shown outside exec");
   property p_load;
      s_ext(9'h19c) ##0 EXEC_MODE && (FLAG_SET | FLAG_CLR) == 6'h00
         |=> FLAGS == $past(OP_ACC[5:0]);
   endproperty
   a_load: assert property (p_load) else $error("flag load wrong");
   property p_mask;
      s_ext(9'h190) |=> INT_MASK == ($past(INT_MASK) | $past(OP_ACC[11:0]));
   endproperty
   a_mask: assert property (p_mask) else $error("mask set wrong");
   property p_jump;
      s_armed ##0 s_jump |=> PROG_STATE && FLAGS[5] && FLAGS[3] && !FLAGS[0];
   endproperty
   a_jump: assert property (p_jump) else $error("no program state");
   property p_par;
      IO_SEND |=> IO_VALID && IO_PARITY == ~^IO_DATA[11:0];
   endproperty
   a_par: assert property (p_par) else $error("io parity wrong");
   property p_bc;
      BC_REQ |=> BC_ACK == !$past(OP_VALID && OP_CODE == 6'h2b);
   endproperty
   a_bc: assert property (p_bc) else $error("file port ack wrong");
endmodule // ccs_properties

bind ccs_core ccs_properties u_props (.*);

// ===== testbench/ccs_bc_model.sv
`timescale 1ns/1ps
// ======
// block control requester, retries while the file port refuses
module ccs_bc_model (
   // clock, reset, bench command
   input  logic       CLOCK,
   input  logic       RESET_N,
   input  logic       go,
   input  logic [3:0] kind,
   output logic       done,
   // file port
   output logic       BC_REQ,
   output logic [3:0] BC_KIND,
   input  logic       BC_ACK
);
   logic wait_reg;
   always @(posedge CLOCK or negedge RESET_N) begin
      if (!RESET_N) begin
         BC_REQ <= 1'h0;
         BC_KIND <= 4'h0;
         wait_reg <= 1'h0;
         done <= 1'h0;
      end else if (go || (wait_reg && !BC_ACK)) begin
         BC_REQ <= 1'h1;
         BC_KIND <= kind;
         wait_reg <= 1'h0;
         done <= 1'h0;
      end else begin
         // released lines turn over so a stale kind shows only every second idle cycle
         BC_KIND <= ~BC_KIND;
         wait_reg <= BC_REQ;
         done <= done | (wait_reg & BC_ACK);
         BC_REQ <= 1'h0;
      end
   end
endmodule // ccs_bc_model

// ===== testbench/ccs_tb_top.sv
`timescale 1ns/1ps
// ======
// bench for the control core
module cpu_control_state_and_register_file_tb_top;
   logic        CLOCK = '0, RESET_N = '0, EXEC_ENTER = '0, EXEC_LEAVE = '0, OP_VALID = '0;
   logic        OP_IS_JUMP = '0, ISR_USE = '1, OPERAND_REF = '0, STO_READ = '0, go = '0;
   logic        STO_WRITE = '0, STO_RVALID = '0, DB_LOAD = '0, IO_SEND = '0, BC_WR = '0;
   logic [5:0]  OP_CODE = '0, OP_RF_ADDR = '0, FLAG_SET = '0, FLAG_CLR = '0;
   logic [8:0]  OP_EXT = '0;
   logic [2:0]  OP_CH = 3'h2, BC_CHAN = '0;
   logic [1:0]  ADDR_SEL = '0, DB_SHIFT = '0;
   logic [3:0]  kind = '0;
   logic [14:0] PC = 15'h1234;
   logic [17:0] INSTR_ADDR = 18'h2abcd, BLOCK_ADDR = 18'h15555, BREAK_ADDR = 18'h0f0f0;
   logic [23:0] OP_ACC = '0, DB_IN = '0, BC_WDATA = '0;
   logic [27:0] STO_RDATA = '0;
   wire         EXEC_MODE, PROG_STATE, TRAP, ACC_VALID, CHAN_VALID, IO_PARITY, IO_VALID;
   wire         STO_WE, STO_RE, RF_RVALID, BC_ACK, BC_REQ, done;
   wire [5:0]   FLAGS;
   wire [11:0]  INT_MASK;
   wire [2:0]   CHAN_IDX, INSTR_STATE, OPER_STATE, IO_CHAN;
   wire [3:0]   BC_KIND;
   wire [17:0]  STO_ADDR;
   wire [23:0]  ACC_OUT, IO_DATA, RF_RDATA;
   wire [27:0]  STO_WDATA;
   int          error_cnt = 0, n_compared = 0;
   logic [5:0]  tc[6] = '{6'h3f, 6'h3f, 6'h2b, 6'h00, 6'h39, 6'h2b};
   logic [5:0]  ent[10] = '{6'h00, 6'h08, 6'h10, 6'h18, 6'h11, 6'h19, 6'h12, 6'h1a, 6'h13, 6'h14};
   logic [23:0] din[3] = '{24'h000001, 24'h000007, 24'h000030};
   logic [23:0] dex[3] = '{24'h001000, 24'h000007, 24'hc00000};
   logic [1:0]  dsh[3] = '{2'h2, 2'h0, 2'h3};
   logic [17:0] sad[4] = '{18'h19234, 18'h2abcd, 18'h15555, 18'h0f0f0};

   initial forever #50 CLOCK = ~CLOCK;
   ccs_core dut (.*);
   ccs_bc_model u_bc (.CLOCK(CLOCK), .RESET_N(RESET_N), .go(go), .kind(kind), .done(done),
                      .BC_REQ(BC_REQ), .BC_KIND(BC_KIND), .BC_ACK(BC_ACK));

   task automatic chk(string nm, logic [27:0] seen, logic [27:0] exp);
      n_compared++;
      if (seen !== exp) begin
         error_cnt++;
         $display("mismatch %s exp %h seen %h", nm, exp, seen);
      end
   endtask
   // one instruction; go always drops here so a file request can coincide
   task automatic op(logic [5:0] c, logic [8:0] x, logic [23:0] a, logic j = 1'h0,
                     logic [5:0] r = 6'h00);
      @(posedge CLOCK);
      OP_VALID <= 1'h1;
      OP_CODE <= c;
      OP_EXT <= x;
      OP_ACC <= a;
      OP_IS_JUMP <= j;
      OP_RF_ADDR <= r;
      go <= 1'h0;
      @(posedge CLOCK);
      OP_VALID <= 1'h0;
      #1;
   endtask
   task automatic cons(logic e, logic l);
      @(posedge CLOCK);
      EXEC_ENTER <= e;
      EXEC_LEAVE <= l;
      @(posedge CLOCK);
      EXEC_ENTER <= 1'h0;
      EXEC_LEAVE <= 1'h0;
      #1;
   endtask
   task automatic finish_test;
      $display("compared %0d mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   // ======
   // watchdog, far beyond the few hundred cycles needed
   initial begin
      #200000;
      error_cnt++;
      finish_test;
   end

   // ======
   // test sequence
   initial begin
      repeat (5) @(posedge CLOCK);
      RESET_N <= 1'h1;
      #1 chk("rst_flags", FLAGS, 6'h00);
      chk("rst_mask", INT_MASK, 12'h000);
      op(6'h3f, 9'h190, 24'h000a5a);
      op(6'h3f, 9'h190, 24'h000100);
      op(6'h3f, 9'h191, 24'h00000f);
      chk("mask", INT_MASK, 12'hb50);
      op(6'h3f, 9'h1a1, 24'h000005);
      chk("cidx", CHAN_IDX, 3'h5);
      op(6'h3f, 9'h1a0, 24'habcdef);
      chk("acc", ACC_OUT, 24'habcded);
      chk("accv", ACC_VALID, 1'h1);
      // last pass uses extension digit 5, which takes no channel
      for (int i = 0; i < 10; i++) begin
         op(i < 4 ? 6'(6'h3b + i) : 6'h3f, i < 4 ? 9'h000 : 9'((i - 4) * 64), 24'h0);
         chk("chvalid", CHAN_VALID, i < 9);
         if (i < 9) chk("chan", IO_CHAN, 3'h7);
      end
      $display("test mask and channel done");
      op(6'h3f, 9'h19c, 24'h00003f);
      chk("flags_off", FLAGS, 6'h10);
      cons(1'h1, 1'h0);
      chk("exec", EXEC_MODE, 1'h1);
      op(6'h3f, 9'h19c, 24'h00000f);
      chk("flags_on", FLAGS, 6'h0f);
      op(6'h3f, 9'h19c, 24'h000000);
      // exempt, exempt, high entry, then three trapping attempts
      for (int i = 0; i < 6; i++) begin
         cons(1'h1, 1'h0);
         op(6'h3f, 9'h1a8, 24'h0);
         chk("armed", FLAGS[0], 1'h1);
         op(6'h22, 9'h000, 24'h0, 1'h1);
         chk("pstate", PROG_STATE, 1'h1);
         chk("pflags", FLAGS & 6'h29, 6'h28);
         op(tc[i], i == 0 ? 9'h1d0 : i == 1 ? 9'h1c8 : 9'h000, 24'h0, 1'h0,
            i == 2 ? 6'h20 : 6'h05);
         chk("trap", TRAP, i > 2);
         chk("flag5", FLAGS[5], i < 3);
      end
      $display("test program state done");
      // every block read collides with an instruction read and must retry
      for (int k = 0; k < 10; k++) begin
         op(6'h2b, 9'h100, 24'h800000 + 24'(k), 1'h0, ent[k]);
         @(posedge CLOCK);
         go <= 1'h1;
         kind <= 4'(k);
         op(6'h2b, 9'h000, 24'h0, 1'h0, 6'h14);
         chk("rfv", RF_RVALID, 1'h1);
         for (int t = 0; t < 20 && !done; t++) @(posedge CLOCK);
         #1 chk("bcread", RF_RDATA, 24'h800000 + 24'(k));
      end
      $display("test register file done");
      for (int i = 0; i < 3; i++) begin
         @(posedge CLOCK);
         DB_LOAD <= 1'h1;
         DB_IN <= din[i];
         DB_SHIFT <= dsh[i];
         @(posedge CLOCK);
         DB_LOAD <= 1'h0;
         IO_SEND <= 1'h1;
         @(posedge CLOCK);
         IO_SEND <= 1'h0;
         #1 chk("iodata", IO_DATA, dex[i]);
         chk("parity", IO_PARITY, i != 1);
      end
      op(6'h3f, 9'h1a2, 24'h000003);
      chk("istate", INSTR_STATE, 3'h3);
      for (int s = 0; s < 4; s++) begin
         @(posedge CLOCK);
         STO_WRITE <= 1'h1;
         ADDR_SEL <= 2'(s);
         @(posedge CLOCK);
         STO_WRITE <= 1'h0;
         #1 chk("addr", STO_ADDR, sad[s]);
      end
      chk("word", STO_WDATA, 28'hfc00000);
      op(6'h3f, 9'h1a3, 24'h000006);
      chk("ostate", OPER_STATE, 3'h6);
      op(6'h3f, 9'h19c, 24'h000004);
      OPERAND_REF <= 1'h1;
      @(posedge CLOCK);
      STO_READ <= 1'h1;
      ADDR_SEL <= 2'h1;
      @(posedge CLOCK);
      STO_READ <= 1'h0;
      #1 chk("reladdr", STO_ADDR, 18'h32bcd);
      chk("rdstrobe", {STO_RE, STO_WE}, 2'h2);
      @(posedge CLOCK);
      STO_RVALID <= 1'h1;
      STO_RDATA <= 28'h8000041;
      DB_SHIFT <= 2'h1;
      @(posedge CLOCK);
      STO_RVALID <= 1'h0;
      IO_SEND <= 1'h1;
      @(posedge CLOCK);
      IO_SEND <= 1'h0;
      #1 chk("zread", STO_WDATA, 28'h8000041);
      chk("dbread", IO_DATA, 24'h001040);
      cons(1'h0, 1'h1);
      chk("leave", EXEC_MODE, 1'h0);
      $display("test storage and io done");
      finish_test;
   end
endmodule // cpu_control_state_and_register_file_tb_top
